/* File: logic/chevc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module chevc_top
	import chevc_pkg::*;
#(
	parameter int WIDTH = CHEVC_WIDTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// register access
	input wire logic EV_WRITE,
	input wire logic [WIDTH-1:0] EV_WDATA,
	output logic [WIDTH-1:0] EV_RDATA,
	input wire logic CLEAR_CHANNEL_EVENTS,
	input wire logic CLEAR_STATUS,
	// mask from the mask register
	input wire logic [WIDTH-1:0] EVENT_MASK,
	// live channel conditions
	input wire logic [WIDTH-1:0] LIVE_STATUS,
	input wire logic OUTPUT_ON,
	input wire logic VOLTAGE_RAMP,
	input wire logic CURRENT_RAMP,
	input wire logic VRAMP_UP,
	input wire logic VRAMP_DOWN,
	input wire logic IRAMP_UP,
	input wire logic IRAMP_DOWN,
	input wire logic OVER_CEILING,
	input wire logic OVER_SETPOINT,
	input wire logic IMMEDIATE_MODE,
	input wire logic DEFERRED_MODE,
	input wire logic ARC_COUNT_OVER,
	// setpoint and switch-on requests
	input wire logic RAISE_REQ,
	input wire logic SWITCH_ON_REQ,
	output logic RAISE_OK,
	output logic SWITCH_ON_OK,
	output logic BLOCKED,
	// module summary contribution
	output logic SUMMARY_EVENT
);
	logic rst_meta_q;
	logic rst_sync_q;
	logic [31:0] ev_q;
	logic [31:0] ev_d;
	logic [31:0] set_vec;
	wire [31:0] clr_vec;
	wire [31:0] blk_vec;
	wire wipe;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	chevc_source u_source (
		.clk(CLK),
		.rst_n(rst_sync_q),
		.live_status(LIVE_STATUS),
		.output_on(OUTPUT_ON),
		.voltage_ramp(VOLTAGE_RAMP),
		.current_ramp(CURRENT_RAMP),
		.ramp_up(VRAMP_UP),
		.ramp_down(VRAMP_DOWN),
		.iramp_up(IRAMP_UP),
		.iramp_down(IRAMP_DOWN),
		.over_ceiling(OVER_CEILING),
		.over_setpoint(OVER_SETPOINT),
		.immediate_mode(IMMEDIATE_MODE),
		.deferred_mode(DEFERRED_MODE),
		.arc_count_over(ARC_COUNT_OVER),
		.set_vec(set_vec)
	);

	// commands and one-writes; set wins so no event is lost
	assign wipe = CLEAR_CHANNEL_EVENTS | CLEAR_STATUS;
	assign clr_vec = wipe ? 32'hffffffff :
		(EV_WRITE ? 32'(EV_WDATA) : 32'h00000000);
	assign ev_d = ((ev_q & ~clr_vec) | set_vec) & CHEVC_IMPL_MASK;

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ev_q <= CHEVC_RESET;
		end else begin
			ev_q <= ev_d;
		end
	end

	// blocking is purely combinational, so it drops the cycle a clear lands
	assign blk_vec = ev_q & 32'(EVENT_MASK) & CHEVC_BLOCK_MASK;
	assign BLOCKED = |blk_vec;
	assign RAISE_OK = RAISE_REQ & ~(BLOCKED & OUTPUT_ON);
	assign SWITCH_ON_OK = SWITCH_ON_REQ & ~(BLOCKED & ~OUTPUT_ON);
	assign SUMMARY_EVENT = |(ev_q & 32'(EVENT_MASK));
	assign EV_RDATA = WIDTH'(ev_q);
endmodule : chevc_top
`default_nettype wire

/* File: logic/chevc_pkg.sv */
package chevc_pkg;
	localparam int CHEVC_WIDTH = 32;
	// event field positions
	localparam int EV_VBOUND_LO = 22;
	localparam int EV_VBOUND_HI = 21;
	localparam int EV_VRAMP_DN = 20;
	localparam int EV_VRAMP_UP = 19;
	localparam int EV_IRAMP_DN = 18;
	localparam int EV_IRAMP_UP = 17;
	localparam int EV_IRAMP_END = 16;
	localparam int EV_VCEIL = 15;
	localparam int EV_ICEIL = 14;
	localparam int EV_TRIP = 13;
	localparam int EV_INHIBIT = 12;
	localparam int EV_VBOUNDS = 11;
	localparam int EV_IBOUNDS = 10;
	localparam int EV_ARC_ERR = 9;
	localparam int EV_CONST_V = 7;
	localparam int EV_CONST_I = 6;
	localparam int EV_EMCY_OFF = 5;
	localparam int EV_VRAMP_END = 4;
	localparam int EV_ON_TO_OFF = 3;
	localparam int EV_INPUT_ERR = 2;
	localparam int EV_ARC = 1;
	// implemented bits: 22..9 and 7..1
	localparam logic [31:0] CHEVC_IMPL_MASK = 32'h007ffefe;
	// blocking-capable bits: 15,14,13,12,9,5
	localparam logic [31:0] CHEVC_BLOCK_MASK = 32'h0000f220;
	// events that switching off counts as on-to-off
	localparam logic [31:0] CHEVC_OFF_CAUSE_MASK = 32'h0000f020;
	localparam logic [31:0] CHEVC_RESET = 32'h00000000;
endpackage : chevc_pkg

/* File: logic/chevc_source.sv */
`timescale 1ns/1ps
`default_nettype none
module chevc_source
	import chevc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// live conditions
	input wire logic [31:0] live_status,
	input wire logic output_on,
	input wire logic voltage_ramp,
	input wire logic current_ramp,
	input wire logic ramp_up,
	input wire logic ramp_down,
	input wire logic iramp_up,
	input wire logic iramp_down,
	input wire logic over_ceiling,
	input wire logic over_setpoint,
	input wire logic immediate_mode,
	input wire logic deferred_mode,
	input wire logic arc_count_over,
	// raw event set vector
	output logic [31:0] set_vec
);
	logic on_q;
	logic vup_q;
	logic vdn_q;
	logic iup_q;
	logic idn_q;
	logic vramp_q;
	logic iramp_q;
	wire off_edge = on_q & ~output_on;
	wire trip_now = (over_ceiling & immediate_mode) |
		(over_setpoint & (immediate_mode | deferred_mode));
	wire off_caused = off_edge & (|(live_status & CHEVC_OFF_CAUSE_MASK));
	wire [31:0] derived;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q <= 1'b0;
			vup_q <= 1'b0;
			vdn_q <= 1'b0;
			iup_q <= 1'b0;
			idn_q <= 1'b0;
			vramp_q <= 1'b0;
			iramp_q <= 1'b0;
		end else begin
			on_q <= output_on;
			vup_q <= ramp_up;
			vdn_q <= ramp_down;
			iup_q <= iramp_up;
			idn_q <= iramp_down;
			vramp_q <= voltage_ramp;
			iramp_q <= current_ramp;
		end
	end
	// ramp starts are rising edges; ramp ends are falling edges
	assign derived = (32'(ramp_up & ~vup_q) << EV_VRAMP_UP) |
		(32'(ramp_down & ~vdn_q) << EV_VRAMP_DN) |
		(32'(iramp_up & ~iup_q) << EV_IRAMP_UP) |
		(32'(iramp_down & ~idn_q) << EV_IRAMP_DN) |
		(32'(vramp_q & ~voltage_ramp) << EV_VRAMP_END) |
		(32'(iramp_q & ~current_ramp) << EV_IRAMP_END) |
		(32'(trip_now) << EV_TRIP) |
		(32'(arc_count_over & off_edge) << EV_ARC_ERR) |
		(32'(off_caused) << EV_ON_TO_OFF);
	// level bits taken straight from live status
	assign set_vec = ((live_status & ~(32'(1) << EV_ON_TO_OFF)) |
		derived) & CHEVC_IMPL_MASK;
endmodule : chevc_source
`default_nettype wire

/* File: bench/chevc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module chevc_assertions
	import chevc_pkg::*;
#(
	parameter int WIDTH = CHEVC_WIDTH
) (
	// watched top ports
	input wire logic CLK, NRST, EV_WRITE, CLEAR_CHANNEL_EVENTS,
	input wire logic CLEAR_STATUS, OUTPUT_ON, OVER_SETPOINT,
	input wire logic DEFERRED_MODE, RAISE_REQ, SWITCH_ON_REQ,
	input wire logic RAISE_OK, SWITCH_ON_OK, BLOCKED, SUMMARY_EVENT,
	input wire logic [WIDTH-1:0] EV_WDATA, EV_RDATA, EVENT_MASK,
	input wire logic [WIDTH-1:0] LIVE_STATUS
);
	// bits fed straight from live status; edge-made bits left out
	localparam logic [31:0] LVL = 32'h0060dce6;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_live_capture: assert property ($past(NRST, 2) |=>
		($past(LIVE_STATUS) & ~EV_RDATA & LVL) == 0) else $error("bit lost");
	a_sticky_w1c: assert property (!CLEAR_CHANNEL_EVENTS && !CLEAR_STATUS
		|=> ($past(EV_RDATA) & ~($past(EV_WDATA) & {WIDTH{$past(EV_WRITE)}})
		& ~EV_RDATA) == 0) else $error("bit dropped");
	a_chan_clear: assert property (CLEAR_CHANNEL_EVENTS |=>
		(EV_RDATA & ~$past(LIVE_STATUS) & LVL) == 0) else $error("not cleared");
	a_status_clear: assert property (CLEAR_STATUS |=>
		(EV_RDATA & ~$past(LIVE_STATUS) & LVL) == 0) else $error("not cleared");
	a_reserved_zero: assert property ((EV_RDATA & ~CHEVC_IMPL_MASK) == 0)
		else $error("reserved bit set");
	a_block_calc: assert property (BLOCKED ==
		|(EV_RDATA & EVENT_MASK & CHEVC_BLOCK_MASK)) else $error("bad block");
	a_raise_gate: assert property (RAISE_REQ && OUTPUT_ON |->
		RAISE_OK == !BLOCKED) else $error("bad raise");
	a_switch_gate: assert property (SWITCH_ON_REQ && !OUTPUT_ON |->
		SWITCH_ON_OK == !BLOCKED) else $error("bad switch");
	a_summary_fwd: assert property (SUMMARY_EVENT ==
		|(EV_RDATA & EVENT_MASK)) else $error("bad summary");
	a_trip_defer: assert property ($past(NRST, 2) && OVER_SETPOINT &&
		DEFERRED_MODE |=> EV_RDATA[EV_TRIP]) else $error("trip missed");
endmodule : chevc_assertions
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, nrst;
	logic [2:0] cmd;
	logic [13:0] ctl;
	logic [31:0] wd, live, mask, rd;
	logic [3:0] st;
	int error_cnt, n_compared;
	chevc_top dut (.CLK(clk), .NRST(nrst), .EV_WRITE(cmd[0]), .EV_WDATA(wd),
		.EV_RDATA(rd), .CLEAR_CHANNEL_EVENTS(cmd[1]), .CLEAR_STATUS(cmd[2]),
		.EVENT_MASK(mask), .LIVE_STATUS(live), .OUTPUT_ON(ctl[0]),
		.VOLTAGE_RAMP(ctl[1]), .CURRENT_RAMP(ctl[2]), .VRAMP_UP(ctl[3]),
		.VRAMP_DOWN(ctl[4]), .IRAMP_UP(ctl[5]), .IRAMP_DOWN(ctl[6]),
		.OVER_CEILING(ctl[7]), .OVER_SETPOINT(ctl[8]),
		.IMMEDIATE_MODE(ctl[9]), .DEFERRED_MODE(ctl[10]),
		.ARC_COUNT_OVER(ctl[11]), .RAISE_REQ(ctl[12]),
		.SWITCH_ON_REQ(ctl[13]), .RAISE_OK(st[0]), .SWITCH_ON_OK(st[1]),
		.BLOCKED(st[2]), .SUMMARY_EVENT(st[3]));
	task test_done;
		if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// #1 lets the combinational gates settle before a compare
	task put(input logic [31:0] l, m, input logic [13:0] c);
		@(negedge clk);
		live = l;
		mask = m;
		ctl = c;
		#1;
	endtask : put
	task cmd_p(input logic [2:0] c, input logic [31:0] d);
		@(negedge clk);
		cmd = c;
		wd = d;
		@(negedge clk);
		cmd = 3'h0;
		#1;
	endtask : cmd_p
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (500) @(posedge clk);
		error_cnt++;
		test_done;
	end
	initial begin
		{nrst, cmd, ctl, wd, live, mask} = '0;
		error_cnt = 0;
		n_compared = 0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		put(32'h0, 32'h0, 14'h0);
		chk("rd", rd, 32'h0);
		// limit event still live on the cycle the output switches off
		put(32'h8000, 32'h0, 14'h1);
		put(32'h8000, 32'h0, 14'h0);
		put(32'h0, 32'h8000, 14'h2000);
		put(32'h0, 32'h8000, 14'h2000);
		chk("rd", rd, 32'h8008);
		chk("st", {29'h0, st[3:1]}, 32'h6);
		put(32'h0, 32'h8000, 14'h1001);
		chk("raise", {31'h0, st[0]}, 32'h0);
		put(32'h0, 32'h0, 14'h1001);
		chk("st", {29'h0, st[3:2], st[0]}, 32'h1);
		put(32'h0, 32'h8, 14'h2000);
		chk("st", {29'h0, st[3:1]}, 32'h5);
		cmd_p(3'h1, 32'hffff7fff);
		chk("rd", rd, 32'h8000);
		cmd_p(3'h1, 32'h8000);
		chk("rd", rd, 32'h0);
		put(32'h0, 32'h0, 14'h500);
		put(32'h0, 32'h0, 14'h0);
		put(32'h0, 32'h0, 14'h0);
		chk("rd", rd, 32'h2000);
		cmd_p(3'h4, 32'h0);
		chk("rd", rd, 32'h0);
		put(32'h0, 32'h0, 14'h809);
		put(32'h0, 32'h0, 14'h800);
		put(32'h0, 32'h0, 14'h0);
		put(32'h0, 32'h0, 14'h0);
		chk("rd", rd, 32'h80200);
		cmd_p(3'h2, 32'h0);
		chk("rd", rd, 32'h0);
		// ramp starts, ramp ends and an immediate-mode trip
		put(32'h0, 32'h0, 14'h296);
		put(32'h0, 32'h0, 14'h60);
		put(32'h0, 32'h0, 14'h0);
		chk("rd", rd, 32'h172010);
		// reserved and bit 3 inputs never show; set beats a one-write
		put(32'hff80010d, 32'h0, 14'h0);
		cmd_p(3'h1, 32'h00172014);
		chk("rd", rd, 32'h4);
		test_done;
	end
endmodule : testbench
bind chevc_top chevc_assertions #(.WIDTH(WIDTH)) chk_i (.CLK, .NRST,
	.EV_WRITE, .CLEAR_CHANNEL_EVENTS, .CLEAR_STATUS, .OUTPUT_ON,
	.OVER_SETPOINT, .DEFERRED_MODE, .RAISE_REQ, .SWITCH_ON_REQ, .RAISE_OK,
	.SWITCH_ON_OK, .BLOCKED, .SUMMARY_EVENT, .EV_WDATA, .EV_RDATA,
	.EVENT_MASK, .LIVE_STATUS);
`default_nettype wire
